// ===== hdl/prbs_bert.sv
// Two-port pseudo-random bit error test generator, receiver and registers.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module prbs_bert
   import prbs_bert_pkg::*;
#(
   parameter int COUNT_W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [15:0] wrData,
   input wire logic wrStb,
   input wire logic rdStb,
   output logic [15:0] rdData,
   input wire logic [1:0] rxBitIn,
   input wire logic [1:0] bitEn,
   output logic [1:0] txBitOut,
   output logic [1:0] txActive,
   output logic irq
);
   if (COUNT_W < 1 || COUNT_W > 16) begin : g_check
      $error("COUNT_W must lie between 1 and 16");
   end

   // Port 0 is local, port 1 is backplane.
   logic [15:0] ctrl_reg, ctrl_next;
   logic [15:0] rdData_reg, rdData_next;
   logic [1:0] irqStatus_reg, irqStatus_next;
   logic [1:0] irqMask_reg, irqMask_next;
   logic [1:0] lockEvt, satEvt;
   logic [1:0] lockFlag;
   logic [15:0] cnt16 [2];
   port_ctrl_t pc [2];

   // Receive pins cross into this clock domain through three flops. A change
   // is taken only once the second and third stages agree.
   logic [1:0] s1_reg, s2_reg, s3_reg, rxBit_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_reg <= 2'h0;
         s2_reg <= 2'h0;
         s3_reg <= 2'h0;
         rxBit_reg <= 2'h0;
      end else begin
         s1_reg <= rxBitIn;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            rxBit_reg <= s3_reg;
         end
      end
   end

   // The enable is delayed three cycles, so the receiver takes each bit one
   // bit time after it left the line. That is harmless for bit times of two
   // clocks or more, and it keeps sampling clear of the filter's settling.
   logic [1:0] en1_reg, en2_reg, en3_reg;
   always_ff @(posedge clk) begin
      if (rst) begin
         en1_reg <= 2'h0;
         en2_reg <= 2'h0;
         en3_reg <= 2'h0;
      end else begin
         en1_reg <= bitEn;
         en2_reg <= en1_reg;
         en3_reg <= en2_reg;
      end
   end

   genvar p;
   for (p = 0; p < 2; p++) begin : g_port
      localparam int B = (p == 1) ? BP_BASE : LO_BASE;
      logic [22:0] gen_reg, gen_next, ref_reg, ref_next;
      logic [COUNT_W-1:0] cnt_reg, cnt_next;
      rx_state_t st_reg, st_next;
      logic tx_reg, tx_next;
      logic txOut_reg, txOut_next;
      logic genBit, genOld, refBit, expBit, rxBit;
      logic rxRise, txRise, clrRise, seedRise;
      logic lockHit, satHit;
      logic [22:0] shifted;
      port_ctrl_t prev_reg;

      assign pc[p].lenLong = ctrl_reg[B + LEN_POS];
      assign pc[p].txStart = ctrl_reg[B + TX_POS];
      assign pc[p].rxStart = ctrl_reg[B + RX_POS];
      assign pc[p].clear = ctrl_reg[B + CLR_POS];
      assign pc[p].reseed = ctrl_reg[B + RESEED_POS];
      assign rxRise = pc[p].rxStart & ~prev_reg.rxStart;
      assign txRise = pc[p].txStart & ~prev_reg.txStart;
      assign clrRise = pc[p].clear & ~prev_reg.clear;
      assign seedRise = pc[p].reseed & ~prev_reg.reseed;
      assign rxBit = rxBit_reg[p];

      assign genBit = pc[p].lenLong ? (gen_reg[22] ^ gen_reg[LONG_TAP - 1])
                                    : (gen_reg[SHORT_LEN - 1]
                                       ^ gen_reg[SHORT_TAP - 1]);
      assign refBit = pc[p].lenLong ? (ref_reg[22] ^ ref_reg[LONG_TAP - 1])
                                    : (ref_reg[SHORT_LEN - 1]
                                       ^ ref_reg[SHORT_TAP - 1]);
      assign expBit = refBit;
      // The oldest stage is sent first, so the seed itself goes out right
      // after a reseed and a receiver locks without waiting a whole period.
      assign genOld = pc[p].lenLong ? gen_reg[PRBS_W - 1]
                                    : gen_reg[SHORT_LEN - 1];
      assign shifted = {ref_reg[21:0], rxBit};

      always_comb begin
         gen_next = gen_reg;
         tx_next = tx_reg;
         txOut_next = txOut_reg;
         if (seedRise) begin
            gen_next = SEED;
         end else if (tx_reg && bitEn[p]) begin
            gen_next = {gen_reg[21:0], genBit};
            txOut_next = genOld;
         end
         if (txRise) begin
            tx_next = 1'b1;
         end else if (!pc[p].txStart) begin
            tx_next = 1'b0;
         end
         if (!tx_next) begin
            txOut_next = 1'b0;
         end
      end

      always_comb begin
         st_next = st_reg;
         ref_next = ref_reg;
         cnt_next = cnt_reg;
         lockHit = 1'b0;
         satHit = 1'b0;
         unique case (st_reg)
            RX_IDLE: begin
               ;
            end
            RX_HUNT: begin
               if (en3_reg[p]) begin
                  ref_next = shifted;
                  if ((pc[p].lenLong && shifted == SEED) ||
                      (!pc[p].lenLong &&
                       shifted[SHORT_LEN-1:0] == SEED[SHORT_LEN-1:0])) begin
                     st_next = RX_LOCKED;
                     lockHit = 1'b1;
                  end
               end
            end
            RX_LOCKED: begin
               if (en3_reg[p]) begin
                  ref_next = {ref_reg[21:0], refBit};
                  // saturating mismatch count
                  // The count stops at its top so a long run never wraps.
                  if (rxBit != expBit && cnt_reg != {COUNT_W{1'b1}}) begin
                     cnt_next = cnt_reg + 1'b1;
                     satHit = (cnt_next == {COUNT_W{1'b1}});
                  end
               end
            end
            default: st_next = RX_IDLE;
         endcase
         if (!pc[p].rxStart) begin
            st_next = RX_IDLE;
         end
         // receive start edge restarts hunt and drops lock
         if (rxRise) begin
            st_next = RX_HUNT;
            ref_next = '0;
         end
         if (clrRise) begin
            cnt_next = '0;
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            gen_reg <= SEED;
            ref_reg <= '0;
            cnt_reg <= '0;
            st_reg <= RX_IDLE;
            tx_reg <= 1'b0;
            txOut_reg <= 1'b0;
            prev_reg <= '0;
         end else begin
            gen_reg <= gen_next;
            ref_reg <= ref_next;
            cnt_reg <= cnt_next;
            st_reg <= st_next;
            tx_reg <= tx_next;
            txOut_reg <= txOut_next;
            prev_reg <= pc[p];
         end
      end

      // lock persists until a new receive start edge
      logic lock_reg, lock_next;
      always_comb begin
         lock_next = lock_reg;
         if (rxRise) begin
            lock_next = 1'b0;
         end else if (lockHit) begin
            lock_next = 1'b1;
         end
      end
      always_ff @(posedge clk) begin
         if (rst) begin
            lock_reg <= 1'b0;
         end else begin
            lock_reg <= lock_next;
         end
      end

      assign lockFlag[p] = lock_reg;
      assign cnt16[p] = 16'(cnt_reg);
      assign txBitOut[p] = txOut_reg;
      assign txActive[p] = tx_reg;
      assign lockEvt[p] = lockHit;
      assign satEvt[p] = satHit;
   end

   always_comb begin
      ctrl_next = ctrl_reg;
      irqMask_next = irqMask_reg;
      irqStatus_next = irqStatus_reg;
      rdData_next = 16'h0000;
      if (wrStb && addr == CTRL_OFFSET) begin
         // reserved and lock bits not writable
         ctrl_next = wrData & CTRL_WRITE_MASK;
      end
      if (wrStb && addr == IRQ_MASK_OFFSET) begin
         irqMask_next = wrData[1:0];
      end
      if (rdStb) begin
         unique case (addr)
            CTRL_OFFSET: begin
               rdData_next = ctrl_reg;
               rdData_next[BP_BASE + LOCK_POS] = lockFlag[1];
               rdData_next[LO_BASE + LOCK_POS] = lockFlag[0];
            end
            BP_COUNT_OFFSET: rdData_next = cnt16[1];
            LO_COUNT_OFFSET: rdData_next = cnt16[0];
            IRQ_STATUS_OFFSET: begin
               rdData_next = {14'h0000, irqStatus_reg};
               irqStatus_next = 2'h0;
            end
            IRQ_MASK_OFFSET: rdData_next = {14'h0000, irqMask_reg};
            default: rdData_next = 16'h0000;
         endcase
      end
      // A new event wins over the clear-on-read, so no event is lost when
      // software reads the status in the cycle in which it happens.
      if (|lockEvt) begin
         irqStatus_next[IRQ_LOCK_POS] = 1'b1;
      end
      if (|satEvt) begin
         irqStatus_next[IRQ_SAT_POS] = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_reg <= CTRL_RESET;
         rdData_reg <= 16'h0000;
         irqStatus_reg <= 2'h0;
         irqMask_reg <= 2'h0;
      end else begin
         ctrl_reg <= ctrl_next;
         rdData_reg <= rdData_next;
         irqStatus_reg <= irqStatus_next;
         irqMask_reg <= irqMask_next;
      end
   end

   assign rdData = rdData_reg;
   assign irq = |(irqStatus_reg & irqMask_reg);
endmodule
`default_nettype wire

// ===== hdl/prbs_bert_pkg.sv
// Package for the two-port pseudo-random bit error test logic.
package prbs_bert_pkg;
   localparam logic [7:0] CTRL_OFFSET = 8'h02;
   localparam logic [7:0] BP_COUNT_OFFSET = 8'h80;
   localparam logic [7:0] LO_COUNT_OFFSET = 8'h81;
   localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h82;
   localparam logic [7:0] IRQ_MASK_OFFSET = 8'h83;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CTRL_WRITE_MASK = 16'h07df;
   // Per-port field positions; the backplane field sits at base 6, local at 0.
   localparam int BP_BASE = 6;
   localparam int LO_BASE = 0;
   localparam int LEN_POS = 0;
   localparam int TX_POS = 1;
   localparam int RX_POS = 2;
   localparam int CLR_POS = 3;
   localparam int RESEED_POS = 4;
   localparam int LOCK_POS = 5;
   localparam int PRBS_W = 23;
   localparam int SHORT_LEN = 15;
   localparam int SHORT_TAP = 14;
   localparam int LONG_TAP = 18;
   localparam logic [22:0] SEED = 23'h7fffff;
   localparam int IRQ_LOCK_POS = 0;
   localparam int IRQ_SAT_POS = 1;

   typedef struct packed {
      logic lenLong;
      logic txStart;
      logic rxStart;
      logic clear;
      logic reseed;
   } port_ctrl_t;

   typedef enum logic [1:0] {
      RX_IDLE,
      RX_HUNT,
      RX_LOCKED
   } rx_state_t;
endpackage

// ===== bench/prbs_bert_monitor.sv
// Port checker for the two-port bit error test block.
`timescale 1ns/1ps
`default_nettype none
module prbs_bert_checker
   import prbs_bert_pkg::*;
#(
   parameter int COUNT_W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [15:0] wrData,
   input wire logic wrStb,
   input wire logic rdStb,
   input wire logic [15:0] rdData,
   input wire logic [1:0] rxBitIn,
   input wire logic [1:0] bitEn,
   input wire logic [1:0] txBitOut,
   input wire logic [1:0] txActive,
   input wire logic irq
);
   logic txReg, txNext, ctrlWr, txRise;
   logic [1:0] maskReg, maskNext;
   assign ctrlWr = wrStb && addr == CTRL_OFFSET;
   assign txRise = ctrlWr && wrData[TX_POS] && !txReg;
   always_comb begin
      txNext = ctrlWr ? wrData[TX_POS] : txReg;
      maskNext = (wrStb && addr == IRQ_MASK_OFFSET) ? wrData[1:0] : maskReg;
   end
   always_ff @(posedge clk) begin
      txReg <= rst ? 1'b0 : txNext;
      maskReg <= rst ? 2'b00 : maskNext;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   rd_idle_a: assert property (!$past(rdStb) |-> rdData == 16'h0000)
      else $error("read data outside its slot");
   ctrl_rsvd_a: assert property (rdStb && addr == CTRL_OFFSET
      |=> rdData[15:12] == 4'h0) else $error("reserved bits not zero");
   unmapped_a: assert property (rdStb && addr != CTRL_OFFSET
      && addr[7:2] != 6'h20 |=> rdData == 16'h0000)
      else $error("unmapped read not zero");
   tx_start_a: assert property (txRise |-> ##2 txActive[0])
      else $error("transmit did not start");
   tx_stop_a: assert property (ctrlWr && !wrData[TX_POS]
      |-> ##2 !txActive[0]) else $error("transmit not disabled");
   tx_quiet_a: assert property (!txActive[0] [*2] |-> !txBitOut[0])
      else $error("bits sent while off");
   count_max_a: assert property (rdStb && addr == LO_COUNT_OFFSET
      |=> (rdData >> COUNT_W) == 16'h0000) else $error("count too wide");
   mask_quiet_a: assert property (maskReg == 2'b00 |-> !irq)
      else $error("masked interrupt raised");
   cover property (txRise);
   cover property (rdStb && addr == LO_COUNT_OFFSET ##1 rdData != 0);
   cover property ($rose(irq));
endmodule
bind prbs_bert prbs_bert_checker #(.COUNT_W(COUNT_W)) chk (.clk(clk),
   .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
   .rdStb(rdStb), .rdData(rdData), .rxBitIn(rxBitIn), .bitEn(bitEn),
   .txBitOut(txBitOut), .txActive(txActive), .irq(irq));
`default_nettype wire

// ===== bench/link_partner.sv
// Loopback far end: bit timing and a return path with injected faults.
`timescale 1ns/1ps
`default_nettype none
module link_partner (
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] txBitOut,
   input wire logic [1:0] flip,
   output logic [1:0] rxBitIn,
   output logic [1:0] bitEn
);
   logic [1:0] phaseReg, phaseNext;
   always_comb phaseNext = phaseReg + 2'h1;
   always_ff @(posedge clk) phaseReg <= rst ? 2'h0 : phaseNext;
   // One bit time is four clocks; the ports are staggered to keep them apart.
   assign bitEn = {phaseReg == 2'h0, phaseReg == 2'h2};
   assign rxBitIn = txBitOut ^ flip;
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the bit error test block.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import prbs_bert_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, wrStb = 1'b0, rdStb = 1'b0, irq;
   logic [7:0] addr = 8'h00;
   logic [15:0] wrData = 16'h0000, rdData;
   logic [1:0] rxBitIn, bitEn, txBitOut, txActive, flip = 2'b00;
   int n_mismatch = 0, tests_run = 0;
   always #12.5 clk = ~clk;
   // A four-bit count keeps saturation within reach of a short run.
   prbs_bert #(.COUNT_W(4)) dut (.clk(clk), .rst(rst), .addr(addr),
      .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
      .rxBitIn(rxBitIn), .bitEn(bitEn), .txBitOut(txBitOut),
      .txActive(txActive), .irq(irq));
   link_partner far (.clk(clk), .rst(rst), .txBitOut(txBitOut),
      .flip(flip), .rxBitIn(rxBitIn), .bitEn(bitEn));
   task automatic final_report;
      if (n_mismatch == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      wrStb <= 1'b1;
      addr <= a;
      wrData <= v;
      @(posedge clk);
      wrStb <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      rdStb <= 1'b1;
      addr <= a;
      @(posedge clk);
      rdStb <= 1'b0;
      #1 check(rdData, exp);
   endtask
   task automatic pins(input logic [1:0] act, input logic irqExp);
      @(posedge clk);
      #1 check({13'h0, irq, txActive}, {13'h0, irqExp, act});
   endtask
   task automatic inject(input int n);
      @(posedge clk);
      flip <= 2'b01;
      repeat (n) @(posedge clk);
      flip <= 2'b00;
      repeat (40) @(posedge clk);
   endtask
   task automatic reset_and_reserved;
      rdchk(LO_COUNT_OFFSET, 16'h0000);
      pins(2'b00, 1'b0);
      check({14'h0, txBitOut}, 16'h0000);
      rdchk(8'h40, 16'h0000);
      wr(CTRL_OFFSET, 16'hf820);
      rdchk(CTRL_OFFSET, CTRL_RESET);
   endtask
   task automatic local_lock;
      wr(CTRL_OFFSET, 16'h0016);
      repeat (200) @(posedge clk);
      rdchk(CTRL_OFFSET, 16'h0036);
      rdchk(LO_COUNT_OFFSET, 16'h0000);
      pins(2'b01, 1'b0);
   endtask
   task automatic count_hold_clear;
      inject(4);
      rdchk(LO_COUNT_OFFSET, 16'h0001);
      wr(CTRL_OFFSET, 16'h0012);
      inject(20);
      rdchk(LO_COUNT_OFFSET, 16'h0001);
      wr(CTRL_OFFSET, 16'h001a);
      repeat (4) @(posedge clk);
      rdchk(LO_COUNT_OFFSET, 16'h0000);
   endtask
   task automatic relock;
      // Transmission is stopped first so that zeros on the line keep the
      // receiver from locking on stray ones just ahead of the new seed.
      wr(CTRL_OFFSET, 16'h0000);
      pins(2'b00, 1'b0);
      check({14'h0, txBitOut}, 16'h0000);
      repeat (8) @(posedge clk);
      wr(CTRL_OFFSET, 16'h0016);
      repeat (4) @(posedge clk);
      rdchk(CTRL_OFFSET, 16'h0016);
      repeat (200) @(posedge clk);
      rdchk(CTRL_OFFSET, 16'h0036);
   endtask
   task automatic saturate_irq;
      wr(IRQ_MASK_OFFSET, 16'h0002);
      rdchk(IRQ_STATUS_OFFSET, 16'h0001);
      inject(100);
      rdchk(LO_COUNT_OFFSET, 16'h000f);
      pins(2'b01, 1'b1);
      wr(IRQ_MASK_OFFSET, 16'h0000);
      pins(2'b01, 1'b0);
      wr(IRQ_MASK_OFFSET, 16'h0002);
      rdchk(IRQ_STATUS_OFFSET, 16'h0002);
      pins(2'b01, 1'b0);
   endtask
   task automatic backplane_long;
      wr(CTRL_OFFSET, 16'h05d6);
      repeat (300) @(posedge clk);
      rdchk(CTRL_OFFSET, 16'h0df6);
      repeat (400) @(posedge clk);
      rdchk(BP_COUNT_OFFSET, 16'h0000);
      pins(2'b11, 1'b0);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      reset_and_reserved();
      local_lock();
      count_hold_clear();
      relock();
      saturate_irq();
      backplane_long();
      final_report();
   end
   initial begin
      // The sequence needs about 1430 clocks; allow roughly three and a half times that.
      #125000;
      n_mismatch++;
      final_report();
   end
endmodule
`default_nettype wire
